// ---- inc/hmc_pkg.sv ----
// Constants and types for the head measurement conditioning block
package hmc_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int SMP_W = 24;
  localparam int WIN_DEPTH = 32;
  localparam int WIN_AW = 5;
  localparam int PERIOD_W = 20;

  // ----------------------------------------------------------------
  // Values and counts
  // ----------------------------------------------------------------
  // Sample and mask point LSB is 1 um; mask points hold 0.01 mm
  localparam logic signed [SMP_W-1:0] MASK_RES_UM = 24'sh00000A;
  localparam logic signed [SMP_W-1:0] SORT_FILL = 24'sh7FFFFF;
  localparam logic [WIN_AW-1:0] WIN_LEN_7 = 5'h07;
  localparam logic [WIN_AW-1:0] WIN_LEN_15 = 5'h0F;
  localparam logic [WIN_AW-1:0] WIN_LEN_31 = 5'h1F;
  // Sampling cycle limits in ns
  localparam logic [PERIOD_W-1:0] SHORT_LO_NS = 20'h009F6;
  localparam logic [PERIOD_W-1:0] SHORT_HI_NS = 20'h02710;
  localparam logic [PERIOD_W-1:0] STD_LO_NS = 20'h04E20;
  localparam logic [PERIOD_W-1:0] STD_HI_NS = 20'hF4240;
  // Specular geometry gain, Q2.14; default is unity
  localparam logic signed [15:0] SPEC_GAIN = 16'sh4000;
  localparam int SPEC_SHIFT = 14;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] RST_SYNC_INIT = 2'h0;
  localparam logic [WIN_AW-1:0] WP_INIT = 5'h00;
  localparam logic [WIN_AW-1:0] CNT_INIT = 5'h00;
  localparam logic [SMP_W-1:0] DATA_INIT = 24'h000000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    HMC_MED_OFF = 2'h0,
    HMC_MED_7 = 2'h1,
    HMC_MED_15 = 2'h2,
    HMC_MED_31 = 2'h3
  } hmc_med_t;

  typedef enum logic [1:0] {
    HMC_IDLE = 2'h0,
    HMC_SORT = 2'h1,
    HMC_EMIT = 2'h3
  } hmc_state_t;

endpackage : hmc_pkg

// ---- logic/hmc_ring.sv ----
// Sample history ring for the running median window
`timescale 1ns/1ns
module hmc_ring import hmc_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic we,
  input wire logic [WIN_AW-1:0] waddr,
  input wire logic [SMP_W-1:0] wdata,
  input wire logic [WIN_AW-1:0] raddr,
  output logic [SMP_W-1:0] rdata
);

  logic [SMP_W-1:0] mem [0:WIN_DEPTH-1];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Read address never equals write address, so no bypass needed
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= DATA_INIT;
    end else begin
      rdata <= mem[raddr];
    end
  end

endmodule : hmc_ring

// ---- logic/hmc_top.sv ----
// Per-head displacement conditioning: mask, mounting, median, laser, range
`timescale 1ns/1ns
// Functional notes
// - Masking acts only while the head's mask switch is on.
// - Start above end excludes every position outside the two points.
// - Start below end excludes every position inside the two points.
// - Equal start and end excludes nothing.
// - Mask points are kept at 0.01 mm, finer parts dropped internally.
// - The median window is 7, 15 or 31 samples long.
// - Each median output is the middle entry of the window sorted by size.
// - Mounting setting zero is diffuse, the other is specular.
// - Specular mounting applies a geometry correction to the value.
// - A K type head always runs specular, whatever is selected.
// - The head belongs to laser group one (0) or group two (1).
// - Laser on/off follows only the control of the head's own group.
// - Cycles of 2.55 to 10 us place the range at center or far side.
// - Cycles of 20 us to 1 ms use the standard range, ignoring far.
module hmc_top import hmc_pkg::*; (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic SMP_VALID,
  input wire logic [SMP_W-1:0] SMP_DATA,
  input wire logic [PERIOD_W-1:0] SMP_PERIOD_NS,
  input wire logic CFG_MASK_ON,
  input wire logic [SMP_W-1:0] CFG_MASK_START,
  input wire logic [SMP_W-1:0] CFG_MASK_END,
  input wire logic [1:0] CFG_MEDIAN,
  input wire logic CFG_MOUNT_SPEC,
  input wire logic CFG_LASER_GROUP,
  input wire logic CFG_RANGE_FAR,
  input wire logic CFG_CONFIRM,
  input wire logic UNIT_MEASURING,
  input wire logic HEAD_K_TYPE,
  input wire logic LASER_GROUP_ONE,
  input wire logic LASER_GROUP_TWO,
  output logic OUT_VALID,
  output logic [SMP_W-1:0] OUT_DATA,
  output logic OUT_MASKED,
  output logic SPECULAR_ACTIVE,
  output logic LASER_ON,
  output logic RANGE_FAR,
  output logic RANGE_STANDARD
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_q;
  logic rst_n;
  logic [2:0] pin_s1;
  logic [2:0] pin_s2;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_q <= RST_SYNC_INIT;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Pins are slow levels, so a plain two-stage sync is enough
  wire [2:0] pin_raw = {HEAD_K_TYPE, LASER_GROUP_TWO, LASER_GROUP_ONE};

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= 3'h0;
      pin_s2 <= 3'h0;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
    end
  end

  wire k_pin = pin_s2[2];
  wire grp_one_pin = pin_s2[0];
  wire grp_two_pin = pin_s2[1];

  // ----------------------------------------------------------------
  // Active settings
  // ----------------------------------------------------------------
  logic confirm_pend;
  logic mask_on;
  logic signed [SMP_W-1:0] mask_p1;
  logic signed [SMP_W-1:0] mask_p2;
  hmc_med_t med_mode;
  logic mount_spec;
  logic laser_group;
  logic range_far;
  wire apply_now = (confirm_pend | CFG_CONFIRM) & UNIT_MEASURING;
  // Truncate to whole 0.01 mm steps
  wire signed [SMP_W-1:0] q_p1 =
    (signed'(CFG_MASK_START) / MASK_RES_UM) * MASK_RES_UM;
  wire signed [SMP_W-1:0] q_p2 =
    (signed'(CFG_MASK_END) / MASK_RES_UM) * MASK_RES_UM;

  // Confirm waits here until the unit is back measuring
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      confirm_pend <= 1'b0;
    end else begin
      confirm_pend <= (confirm_pend | CFG_CONFIRM) & ~UNIT_MEASURING;
    end
  end

  // Settings only load once the unit is back measuring
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      mask_on <= 1'b0;
      mask_p1 <= DATA_INIT;
      mask_p2 <= DATA_INIT;
      med_mode <= HMC_MED_OFF;
      mount_spec <= 1'b0;
      laser_group <= 1'b0;
      range_far <= 1'b0;
    end else if (apply_now) begin
      mask_on <= CFG_MASK_ON;
      mask_p1 <= q_p1;
      mask_p2 <= q_p2;
      med_mode <= hmc_med_t'(CFG_MEDIAN);
      mount_spec <= CFG_MOUNT_SPEC;
      laser_group <= CFG_LASER_GROUP;
      range_far <= CFG_RANGE_FAR;
    end
  end

  // ----------------------------------------------------------------
  // Mask decision and mounting correction
  // ----------------------------------------------------------------
  wire signed [SMP_W-1:0] smp = signed'(SMP_DATA);
  wire in_band_fwd = (smp >= mask_p1) && (smp <= mask_p2);
  wire out_band_rev = (smp > mask_p1) || (smp < mask_p2);
  wire excl_inside = (mask_p1 < mask_p2) && in_band_fwd;
  wire excl_outside = (mask_p1 > mask_p2) && out_band_rev;
  // Equal points fall into neither term
  wire excluded = mask_on & (excl_inside | excl_outside);
  wire spec_eff = mount_spec | k_pin;
  wire signed [SMP_W+15:0] spec_prod = smp * SPEC_GAIN;
  wire signed [SMP_W+15:0] spec_shift = spec_prod >>> SPEC_SHIFT;
  wire signed [SMP_W-1:0] corr =
    spec_eff ? spec_shift[SMP_W-1:0] : smp;

  // ----------------------------------------------------------------
  // Median window
  // ----------------------------------------------------------------
  hmc_state_t state;
  hmc_state_t next_state;
  logic [WIN_AW-1:0] wp;
  logic [WIN_AW-1:0] cnt;
  logic signed [SMP_W-1:0] new_val;
  logic [SMP_W-1:0] old_raw;
  logic signed [SMP_W-1:0] srt_q [0:WIN_DEPTH-1];
  logic signed [SMP_W-1:0] del_v [0:WIN_DEPTH-1];
  logic signed [SMP_W-1:0] ins_v [0:WIN_DEPTH-1];
  logic [WIN_DEPTH-1:0] del_ge;
  logic [WIN_DEPTH-1:0] ins_gt;

  wire [WIN_AW-1:0] win_len =
    (med_mode == HMC_MED_7) ? WIN_LEN_7 :
    (med_mode == HMC_MED_15) ? WIN_LEN_15 : WIN_LEN_31;
  wire [WIN_AW-1:0] mid_idx = win_len >> 1;
  wire med_on = (med_mode != HMC_MED_OFF);
  wire take = SMP_VALID && (state == HMC_IDLE) && !excluded;
  wire take_med = take && med_on;
  wire full = (cnt == win_len);
  wire sort_step = (state == HMC_SORT);
  wire [WIN_AW-1:0] oldest_addr = wp - win_len;
  wire signed [SMP_W-1:0] old_val = signed'(old_raw);

  // Sort and emit take one cycle each
  always_comb begin
    case (state)
      HMC_IDLE: begin
        next_state = take_med ? HMC_SORT : HMC_IDLE;
      end
      HMC_SORT: begin
        next_state = HMC_EMIT;
      end
      HMC_EMIT: begin
        next_state = HMC_IDLE;
      end
      default: begin
        next_state = HMC_IDLE;
      end
    endcase
  end

  hmc_ring u_ring (
    .clk(CLK),
    .rst_n(rst_n),
    .we(take_med),
    .waddr(wp),
    .wdata(corr),
    .raddr(oldest_addr),
    .rdata(old_raw)
  );

  // Sorted list ascending; unused slots hold the largest code so they
  // always sit at the top and fall off first.
  genvar gi;
  generate
    for (gi = 0; gi < WIN_DEPTH; gi++) begin : g_slot
      assign del_ge[gi] = full && (srt_q[gi] >= old_val);
      if (gi == WIN_DEPTH - 1) begin : g_top
        assign del_v[gi] = del_ge[gi] ? SORT_FILL : srt_q[gi];
      end else begin : g_mid
        assign del_v[gi] = del_ge[gi] ? srt_q[gi+1] : srt_q[gi];
      end
      assign ins_gt[gi] = del_v[gi] > new_val;
      if (gi == 0) begin : g_bot
        assign ins_v[gi] = ins_gt[gi] ? new_val : del_v[gi];
      end else begin : g_up
        assign ins_v[gi] = !ins_gt[gi] ? del_v[gi] :
                           ins_gt[gi-1] ? del_v[gi-1] : new_val;
      end
      always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
          srt_q[gi] <= SORT_FILL;
        end else if (apply_now) begin
          srt_q[gi] <= SORT_FILL;
        end else if (sort_step) begin
          srt_q[gi] <= ins_v[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Window control
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      state <= HMC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      wp <= WP_INIT;
      new_val <= DATA_INIT;
    end else if (take_med) begin
      wp <= wp + 5'h01;
      new_val <= corr;
    end
  end

  // A new window length starts an empty window
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= CNT_INIT;
    end else if (apply_now) begin
      cnt <= CNT_INIT;
    end else if (sort_step && !full) begin
      cnt <= cnt + 5'h01;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  wire emit_med = (state == HMC_EMIT) && full;
  wire emit_raw = take && !med_on;
  wire short_cyc = (SMP_PERIOD_NS >= SHORT_LO_NS) &&
                   (SMP_PERIOD_NS <= SHORT_HI_NS);
  wire std_cyc = (SMP_PERIOD_NS >= STD_LO_NS) &&
                 (SMP_PERIOD_NS <= STD_HI_NS);
  wire laser_sel = laser_group ? grp_two_pin : grp_one_pin;
  wire mask_hit = SMP_VALID && (state == HMC_IDLE) && excluded;

  // Median result waits for the emit state
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      OUT_VALID <= 1'b0;
      OUT_DATA <= DATA_INIT;
      OUT_MASKED <= 1'b0;
    end else begin
      OUT_VALID <= emit_med | emit_raw;
      if (emit_med) begin
        OUT_DATA <= srt_q[mid_idx];
      end else if (emit_raw) begin
        OUT_DATA <= corr;
      end
      OUT_MASKED <= mask_hit;
    end
  end

  // Level outputs follow settings, synced pins and the sample period one cycle later
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      SPECULAR_ACTIVE <= 1'b0;
      LASER_ON <= 1'b0;
      RANGE_FAR <= 1'b0;
      RANGE_STANDARD <= 1'b0;
    end else begin
      SPECULAR_ACTIVE <= spec_eff;
      LASER_ON <= laser_sel;
      RANGE_FAR <= short_cyc & range_far;
      RANGE_STANDARD <= std_cyc;
    end
  end

endmodule : hmc_top

// ---- test/hmc_top_asserts.sv ----
// Port-level checker for the head conditioning block
`timescale 1ns/1ns
module hmc_top_chk import hmc_pkg::*; (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic SMP_VALID,
  input wire logic [PERIOD_W-1:0] SMP_PERIOD_NS,
  input wire logic HEAD_K_TYPE,
  input wire logic LASER_GROUP_ONE,
  input wire logic LASER_GROUP_TWO,
  input wire logic OUT_VALID,
  input wire logic [SMP_W-1:0] OUT_DATA,
  input wire logic OUT_MASKED,
  input wire logic SPECULAR_ACTIVE,
  input wire logic LASER_ON,
  input wire logic RANGE_FAR,
  input wire logic RANGE_STANDARD
);
  // ----
  // Settle time
  // ----
  // Internal reset and pin syncs lag RST_B
  logic [2:0] up;
  logic ok;
  assign ok = up == 3'h7;
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) up <= 3'h0;
    else if (!ok) up <= up + 3'h1;
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  sequence k_held;
    ok ##0 HEAD_K_TYPE [*4];
  endsequence
  out_excl_a: assert property (!(OUT_VALID && OUT_MASKED))
    else $error("valid with masked");
  valid_cause_a: assert property (OUT_VALID |->
    $past(SMP_VALID) || $past(SMP_VALID, 3))
    else $error("valid without sample");
  mask_cause_a: assert property (OUT_MASKED |-> $past(SMP_VALID))
    else $error("masked without sample");
  std_range_a: assert property (ok |-> RANGE_STANDARD ==
    ($past(SMP_PERIOD_NS) >= STD_LO_NS && $past(SMP_PERIOD_NS) <= STD_HI_NS))
    else $error("standard range wrong");
  far_range_a: assert property (ok && RANGE_FAR |->
    $past(SMP_PERIOD_NS) >= SHORT_LO_NS && $past(SMP_PERIOD_NS) <= SHORT_HI_NS)
    else $error("far range outside short cycle");
  laser_rise_a: assert property ($rose(LASER_ON) |->
    $past(LASER_GROUP_ONE, 3) || $past(LASER_GROUP_TWO, 3))
    else $error("laser on without pin");
  k_spec_a: assert property (k_held |=> SPECULAR_ACTIVE)
    else $error("k head not specular");
  data_hold_a: assert property (ok && !OUT_VALID |-> $stable(OUT_DATA))
    else $error("data moved without valid");
endmodule : hmc_top_chk
bind hmc_top hmc_top_chk hmc_top_chk_i (.CLK(CLK), .RST_B(RST_B),
  .SMP_VALID(SMP_VALID), .SMP_PERIOD_NS(SMP_PERIOD_NS),
  .HEAD_K_TYPE(HEAD_K_TYPE), .LASER_GROUP_ONE(LASER_GROUP_ONE),
  .LASER_GROUP_TWO(LASER_GROUP_TWO), .OUT_VALID(OUT_VALID),
  .OUT_DATA(OUT_DATA), .OUT_MASKED(OUT_MASKED),
  .SPECULAR_ACTIVE(SPECULAR_ACTIVE), .LASER_ON(LASER_ON),
  .RANGE_FAR(RANGE_FAR), .RANGE_STANDARD(RANGE_STANDARD));

// ---- test/hmc_head_model.sv ----
// Sensor head front end model: one-cycle sample pulses
`timescale 1ns/1ns
module hmc_head_model import hmc_pkg::*; (
  input wire logic clk,
  input wire logic req,
  input wire logic [SMP_W-1:0] val,
  output logic smp_valid,
  output logic [SMP_W-1:0] smp_data
);
  initial begin
    smp_valid = 1'b0;
    smp_data = DATA_INIT;
  end
  // Idle data toggles so a stale sample never looks valid
  always @(posedge clk) begin
    smp_valid <= req;
    smp_data <= req ? val : ~smp_data;
  end
endmodule : hmc_head_model

// ---- test/hmc_top_tb_top.sv ----
// Self-checking bench for the head conditioning block
`timescale 1ns/1ns
module hmc_top_tb_top import hmc_pkg::*;;
  logic CLK = 1'b0, RST_B = 1'b0, CFG_MASK_ON = 1'b0, CFG_CONFIRM = 1'b0;
  logic CFG_MOUNT_SPEC = 1'b0, CFG_LASER_GROUP = 1'b0, CFG_RANGE_FAR = 1'b0;
  logic UNIT_MEASURING = 1'b1, HEAD_K_TYPE = 1'b0, req = 1'b0;
  logic LASER_GROUP_ONE = 1'b0, LASER_GROUP_TWO = 1'b0;
  logic [1:0] CFG_MEDIAN = 2'h0;
  logic [SMP_W-1:0] CFG_MASK_START = DATA_INIT, CFG_MASK_END = DATA_INIT;
  logic [SMP_W-1:0] val = DATA_INIT, SMP_DATA, OUT_DATA, seen_d;
  logic [PERIOD_W-1:0] SMP_PERIOD_NS = 20'h04E20;
  logic SMP_VALID, OUT_VALID, OUT_MASKED, SPECULAR_ACTIVE, LASER_ON;
  logic RANGE_FAR, RANGE_STANDARD;
  int nv = 0, nm = 0, cyc = 0, failures = 0, total_checks = 0;
  hmc_head_model hmc_head_model_i (.clk(CLK), .req(req), .val(val),
    .smp_valid(SMP_VALID), .smp_data(SMP_DATA));
  hmc_top hmc_top_i (.CLK(CLK), .RST_B(RST_B), .SMP_VALID(SMP_VALID),
    .SMP_DATA(SMP_DATA), .SMP_PERIOD_NS(SMP_PERIOD_NS),
    .CFG_MASK_ON(CFG_MASK_ON), .CFG_MASK_START(CFG_MASK_START),
    .CFG_MASK_END(CFG_MASK_END), .CFG_MEDIAN(CFG_MEDIAN),
    .CFG_MOUNT_SPEC(CFG_MOUNT_SPEC), .CFG_LASER_GROUP(CFG_LASER_GROUP),
    .CFG_RANGE_FAR(CFG_RANGE_FAR), .CFG_CONFIRM(CFG_CONFIRM),
    .UNIT_MEASURING(UNIT_MEASURING), .HEAD_K_TYPE(HEAD_K_TYPE),
    .LASER_GROUP_ONE(LASER_GROUP_ONE), .LASER_GROUP_TWO(LASER_GROUP_TWO),
    .OUT_VALID(OUT_VALID), .OUT_DATA(OUT_DATA), .OUT_MASKED(OUT_MASKED),
    .SPECULAR_ACTIVE(SPECULAR_ACTIVE), .LASER_ON(LASER_ON),
    .RANGE_FAR(RANGE_FAR), .RANGE_STANDARD(RANGE_STANDARD));
  always #50 CLK = ~CLK;
  // ----
  // Output monitor and hang guard
  // ----
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (OUT_VALID === 1'b1) begin
      nv <= nv + 1;
      seen_d <= OUT_DATA;
    end
    if (OUT_MASKED === 1'b1) nm <= nm + 1;
    if (cyc == 5000) begin
      failures++;
      end_of_test();
    end
  end
  task automatic chk(input string what, input logic [31:0] s, e);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s expected %0h seen %0h", what, e, s);
    end
  endtask : chk
  task automatic confirm;
    CFG_CONFIRM <= 1'b1;
    @(posedge CLK);
    CFG_CONFIRM <= 1'b0;
    repeat (5) @(posedge CLK);
  endtask : confirm
  task automatic send(input logic [SMP_W-1:0] x, input logic [31:0] ev, em,
    input logic [SMP_W-1:0] ed);
    int v0, m0;
    v0 = nv;
    m0 = nm;
    req <= 1'b1;
    val <= x;
    @(posedge CLK);
    req <= 1'b0;
    repeat (7) @(posedge CLK);
    chk("out_valid", nv - v0, ev);
    chk("out_masked", nm - m0, em);
    if (ev == 1) chk("out_data", seen_d, ed);
  endtask : send
  task automatic mcase(input logic on, input logic [SMP_W-1:0] s, e, x,
    input logic m);
    CFG_MASK_ON <= on;
    CFG_MASK_START <= s;
    CFG_MASK_END <= e;
    confirm();
    send(x, !m, m, x);
  endtask : mcase
  task automatic t_mask;
    mcase(1'b0, 24'h000064, 24'h0000C8, 24'h000096, 1'b0);
    mcase(1'b1, 24'h000064, 24'h0000C8, 24'h000064, 1'b1);
    mcase(1'b1, 24'h000064, 24'h0000C8, 24'h0000FA, 1'b0);
    mcase(1'b1, 24'h0000C8, 24'h000064, 24'h000096, 1'b0);
    mcase(1'b1, 24'h0000C8, 24'h000064, 24'h000032, 1'b1);
    mcase(1'b1, 24'h0000C8, 24'h000064, 24'h0000FA, 1'b1);
    mcase(1'b1, 24'h000069, 24'h0000D1, 24'h000066, 1'b1);
    mcase(1'b1, 24'h000069, 24'h0000D1, 24'h0000CD, 1'b0);
    mcase(1'b1, 24'h000064, 24'h000064, 24'h000064, 1'b0);
  endtask : t_mask
  // Window holds a permutation of 0..n-1, so the middle is (n-1)/2
  task automatic t_med(input logic [1:0] md, input int n);
    CFG_MEDIAN <= md;
    confirm();
    for (int i = 0; i < n; i++) begin
      send(SMP_W'((i * 4) % n), i == n - 1, 0, SMP_W'((n - 1) / 2));
    end
    send(24'h000064, 1, 0, SMP_W'((n + 1) / 2));
  endtask : t_med
  task automatic t_spec;
    logic signed [39:0] p;
    p = (40'sh00000003E8 * SPEC_GAIN) >>> SPEC_SHIFT;
    CFG_MEDIAN <= 2'h0;
    confirm();
    chk("specular", SPECULAR_ACTIVE, 0);
    CFG_MOUNT_SPEC <= 1'b1;
    confirm();
    chk("specular", SPECULAR_ACTIVE, 1);
    send(24'h0003E8, 1, 0, p[SMP_W-1:0]);
    CFG_MOUNT_SPEC <= 1'b0;
    HEAD_K_TYPE <= 1'b1;
    confirm();
    chk("specular", SPECULAR_ACTIVE, 1);
    HEAD_K_TYPE <= 1'b0;
  endtask : t_spec
  task automatic t_laser;
    for (int g = 0; g < 2; g++) begin
      CFG_LASER_GROUP <= g[0];
      LASER_GROUP_ONE <= 1'b1;
      LASER_GROUP_TWO <= 1'b0;
      confirm();
      chk("laser_on", LASER_ON, !g[0]);
      LASER_GROUP_ONE <= 1'b0;
      LASER_GROUP_TWO <= 1'b1;
      repeat (5) @(posedge CLK);
      chk("laser_on", LASER_ON, g[0]);
    end
  endtask : t_laser
  task automatic rcase(input logic far, input logic [PERIOD_W-1:0] p,
    input logic ef, es);
    SMP_PERIOD_NS <= p;
    CFG_RANGE_FAR <= far;
    confirm();
    chk("range_far", RANGE_FAR, ef);
    chk("range_std", RANGE_STANDARD, es);
  endtask : rcase
  task automatic t_range;
    rcase(1'b1, 20'h009F6, 1'b1, 1'b0);
    rcase(1'b1, 20'h02710, 1'b1, 1'b0);
    rcase(1'b1, 20'h009F5, 1'b0, 1'b0);
    rcase(1'b0, 20'h01388, 1'b0, 1'b0);
    rcase(1'b1, 20'h04E20, 1'b0, 1'b1);
    rcase(1'b1, 20'hF4240, 1'b0, 1'b1);
    rcase(1'b1, 20'hF4241, 1'b0, 1'b0);
  endtask : t_range
  task automatic t_pend;
    rcase(1'b0, 20'h01388, 1'b0, 1'b0);
    CFG_RANGE_FAR <= 1'b1;
    UNIT_MEASURING <= 1'b0;
    confirm();
    chk("range_far", RANGE_FAR, 0);
    UNIT_MEASURING <= 1'b1;
    repeat (5) @(posedge CLK);
    chk("range_far", RANGE_FAR, 1);
  endtask : t_pend
  task automatic end_of_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (12) @(posedge CLK);
    RST_B <= 1'b1;
    repeat (6) @(posedge CLK);
    t_mask();
    t_med(2'h1, 7);
    t_med(2'h2, 15);
    t_med(2'h3, 31);
    t_spec();
    t_laser();
    t_range();
    t_pend();
    end_of_test();
  end
endmodule : hmc_top_tb_top
